// ===== rtl/mgcs_pkg.sv
package mgcs_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [21:0] OFS_ID = 22'h000000;
  localparam logic [21:0] OFS_FRAMES = 22'h000004;
  localparam logic [21:0] OFS_CYCLES = 22'h000008;
  localparam logic [21:0] OFS_FREQ = 22'h00000C;
  localparam logic [21:0] OFS_DIR = 22'h000098;
  localparam logic [21:0] OFS_LEVEL = 22'h00009C;
  localparam logic [21:0] OFS_WIDTH = 22'h000188;
  localparam logic [21:0] OFS_TRIM = 22'h10256C;

  // ==========================================================================
  // Reset values.
  localparam logic [31:0] RST_FREQ = 32'h03938700;
  localparam logic [31:0] RST_DIR = 32'h00008000;
  localparam logic [31:0] RST_LEVEL = 32'h00008000;
  localparam logic [4:0] RST_TRIM = 5'h00;
  localparam logic [2:0] RST_WIDTH = 3'h0;

  // ==========================================================================
  // Field positions.
  localparam int DISPLAY_ENABLE_PIN_BIT = 15;
  localparam int GPIO_DRV_LSB = 13;
  localparam int LCD_DRV_BIT = 12;
  localparam int HOST_DRV_LSB = 10;
  localparam int INT_TYPE_BIT = 9;
  localparam int DUMMY_BIT = 2;
  localparam logic [1:0] WIDTH_UNDEF = 2'h3;

  // Bus width codes.
  typedef enum logic [1:0] {
    MGCS_W1 = 2'b00,
    MGCS_W2 = 2'b01,
    MGCS_W4 = 2'b10
  } mgcs_width_e;

endpackage

// ===== rtl/mgcs_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Direction bits 3..0 set each pin as output (1) or input (0).
// - Direction bit 15 sets the display-enable pin direction, reset 0x8000.
// - Small variants keep only lines 1 and 0; large variants keep all four.
// - Level bit 15 drives and returns the display-enable level, reset 0x8000.
// - Level bits 3..0 set pin output levels and read back the pin levels.
// - Three drive-strength fields at 14-13, 12 and 11-10, reset lowest.
// - Level bit 9 picks open-drain (0) or push-pull (1) interrupt output.
// - The frequency register holds the clock in hertz, reset 0x3938700.
// - The cycle counter clears at reset and counts every clock, wrapping.
// - The frame counter clears at reset and counts finished frames.
// - A fixed read-only identity byte sits at offset zero.
// - Width bit 2 adds one dummy byte to every host read.
// - Width bits 1..0 pick one, two or four data lines; 11 is undefined.
module mgcs_regs #(
  parameter int GPIO_LINES = 4,
  parameter logic [7:0] ID_VALUE = 8'h5A  // Arbitrary identity value.
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event from the display timing
  input wire logic frame_done,
  // Pins
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic display_enable_pin,
  output logic display_enable_oe,
  // Pad and host link controls
  output logic [1:0] gpio_drive,
  output logic lcd_drive,
  output logic [1:0] host_drive,
  output logic int_push_pull,
  output logic [1:0] host_bus_width,
  output logic read_dummy_byte,
  output logic [4:0] oscillator_trim
);

  // ==========================================================================
  // Storage.
  localparam logic [3:0] GPIO_MASK = 4'((1 << GPIO_LINES) - 1);

  logic [3:0] dir_reg, dir_next;
  logic display_enable_pin_dir_reg, display_enable_pin_dir_next;
  logic [3:0] lvl_reg, lvl_next;
  logic display_enable_pin_lvl_reg, display_enable_pin_lvl_next;
  logic [1:0] gdrv_reg, gdrv_next;
  logic ldrv_reg, ldrv_next;
  logic [1:0] hdrv_reg, hdrv_next;
  logic inttype_reg, inttype_next;
  logic [31:0] freq_reg, freq_next;
  logic [31:0] cyc_reg, cyc_next;
  logic [31:0] frm_reg, frm_next;
  logic [4:0] trim_reg, trim_next;
  logic [2:0] width_reg, width_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [3:0] gin_s1_reg, gin_s2_reg;
  logic frm_s1_reg, frm_s2_reg, frm_s3_reg;
  // Direction and level are split per field, so reserved bits have no
  // storage at all and cannot hold stray values.

  logic wr, rd;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  // ==========================================================================
  // Helpers.
  // Only the low 22 address bits are decoded, so the bank aliases above them.
  function automatic logic [21:0] local_addr(input logic [31:0] addr);
    return addr[21:0];
  endfunction

  // lines above GPIO_LINES do not exist and stay zero.
  function automatic logic [3:0] keep_lines(input logic [3:0] bits);
    return bits & GPIO_MASK;
  endfunction

  // an output line reads its driven level, an input line its pad.
  function automatic logic [3:0] pin_view(input logic [3:0] dir,
                                          input logic [3:0] lvl,
                                          input logic [3:0] pad);
    return keep_lines((dir & lvl) | (~dir & pad));
  endfunction

  // A write takes effect in the access phase; zero wait states.
  // Read data is captured in the setup cycle so that it already stands
  // when the master samples it in the access cycle.
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  // Two-stage synchronisers for pin inputs and the frame event.
  // Only the second stage reads the first; the third frame flop just keeps
  // the last synchronised level for the edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gin_s1_reg <= 4'h0;
      gin_s2_reg <= 4'h0;
      frm_s1_reg <= 1'b0;
      frm_s2_reg <= 1'b0;
      frm_s3_reg <= 1'b0;
    end else begin
      gin_s1_reg <= gpio_in;
      gin_s2_reg <= gin_s1_reg;
      frm_s1_reg <= frame_done;
      frm_s2_reg <= frm_s1_reg;
      frm_s3_reg <= frm_s2_reg;
    end
  end

  // ==========================================================================
  // Free-running counters.
  // A frame is counted on the rising edge of the synchronised event, so a
  // long frame_done level still counts only once.
  // The cycle counter has no enable; it simply wraps after 2^32 clocks.
  logic frame_edge;

  always_comb begin
    // free cycle count, wraps by overflow
    cyc_next = cyc_reg + 32'h00000001;
    frame_edge = frm_s2_reg & ~frm_s3_reg;
    frm_next = frm_reg + {31'h00000000, frame_edge};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= 32'h00000000;
      frm_reg <= 32'h00000000;
    end else begin
      cyc_reg <= cyc_next;
      frm_reg <= frm_next;
    end
  end

  // ==========================================================================
  // Bus response.
  // The bank never stretches a transfer and never reports an error; both
  // answers still come from flip-flops so the bus outputs are glitch free.
  always_comb begin
    pready_next = 1'b1;
    pslverr_next = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Next-state logic.
  // Writes land at the access edge, so a read that follows at once sees the
  // new value.
  always_comb begin
    dir_next = dir_reg;
    display_enable_pin_dir_next = display_enable_pin_dir_reg;
    lvl_next = lvl_reg;
    display_enable_pin_lvl_next = display_enable_pin_lvl_reg;
    gdrv_next = gdrv_reg;
    ldrv_next = ldrv_reg;
    hdrv_next = hdrv_reg;
    inttype_next = inttype_reg;
    freq_next = freq_reg;
    trim_next = trim_reg;
    width_next = width_reg;
    if (wr) begin
      case (local_addr(paddr))
        mgcs_pkg::OFS_DIR: begin
          // pin directions, absent lines stay zero
          dir_next = keep_lines(pwdata[3:0]);
          display_enable_pin_dir_next = pwdata[mgcs_pkg::DISPLAY_ENABLE_PIN_BIT];
        end
        mgcs_pkg::OFS_LEVEL: begin
          lvl_next = keep_lines(pwdata[3:0]);
          display_enable_pin_lvl_next = pwdata[mgcs_pkg::DISPLAY_ENABLE_PIN_BIT];
          gdrv_next = pwdata[mgcs_pkg::GPIO_DRV_LSB +: 2];
          ldrv_next = pwdata[mgcs_pkg::LCD_DRV_BIT];
          hdrv_next = pwdata[mgcs_pkg::HOST_DRV_LSB +: 2];
          inttype_next = pwdata[mgcs_pkg::INT_TYPE_BIT];
        end
        mgcs_pkg::OFS_FREQ: freq_next = pwdata;
        mgcs_pkg::OFS_TRIM: trim_next = pwdata[4:0];
        mgcs_pkg::OFS_WIDTH: begin
          // dummy byte, width; the undefined code is not stored.
          // Refusing it keeps the host link in a usable mode: a host that
          // writes it keeps its old width.
          width_next[mgcs_pkg::DUMMY_BIT] = pwdata[mgcs_pkg::DUMMY_BIT];
          if (pwdata[1:0] != mgcs_pkg::WIDTH_UNDEF) begin
            width_next[1:0] = pwdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Read mux; reserved bits and unmapped addresses read zero.
  always_comb begin
    prdata_next = prdata_reg;
    if (rd) begin
      // Counters are sampled at the setup edge of the read.
      case (local_addr(paddr))
        mgcs_pkg::OFS_ID: prdata_next = {24'h000000, ID_VALUE};
        mgcs_pkg::OFS_FRAMES: prdata_next = frm_reg;
        mgcs_pkg::OFS_CYCLES: prdata_next = cyc_reg;
        mgcs_pkg::OFS_FREQ: prdata_next = freq_reg;
        mgcs_pkg::OFS_DIR: prdata_next = {16'h0000, display_enable_pin_dir_reg, 11'h000,
                                          dir_reg};
        // read back actual pin levels: driven or sampled
        mgcs_pkg::OFS_LEVEL: prdata_next = {16'h0000, display_enable_pin_lvl_reg,
          gdrv_reg, ldrv_reg, hdrv_reg, inttype_reg, 5'h00,
          pin_view(dir_reg, lvl_reg, gin_s2_reg)};
        mgcs_pkg::OFS_WIDTH: prdata_next = {29'h0, width_reg};
        mgcs_pkg::OFS_TRIM: prdata_next = {27'h0, trim_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= mgcs_pkg::RST_DIR[3:0];
      display_enable_pin_dir_reg <= mgcs_pkg::RST_DIR[mgcs_pkg::DISPLAY_ENABLE_PIN_BIT];
      lvl_reg <= mgcs_pkg::RST_LEVEL[3:0];
      display_enable_pin_lvl_reg <= mgcs_pkg::RST_LEVEL[mgcs_pkg::DISPLAY_ENABLE_PIN_BIT];
      gdrv_reg <= 2'h0;
      ldrv_reg <= 1'b0;
      hdrv_reg <= 2'h0;
      inttype_reg <= 1'b0;
      freq_reg <= mgcs_pkg::RST_FREQ;
      trim_reg <= mgcs_pkg::RST_TRIM;
      width_reg <= mgcs_pkg::RST_WIDTH;
      prdata_reg <= 32'h00000000;
    end else begin
      dir_reg <= dir_next;
      display_enable_pin_dir_reg <= display_enable_pin_dir_next;
      lvl_reg <= lvl_next;
      display_enable_pin_lvl_reg <= display_enable_pin_lvl_next;
      gdrv_reg <= gdrv_next;
      ldrv_reg <= ldrv_next;
      hdrv_reg <= hdrv_next;
      inttype_reg <= inttype_next;
      freq_reg <= freq_next;
      trim_reg <= trim_next;
      width_reg <= width_next;
      prdata_reg <= prdata_next;
    end
  end

  // ==========================================================================
  // Outputs come straight from flip-flops.
  // Pad controls follow their registers with no extra delay.
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign gpio_out = lvl_reg;
  assign gpio_oe = dir_reg;
  assign display_enable_pin = display_enable_pin_lvl_reg;
  assign display_enable_oe = display_enable_pin_dir_reg;
  assign gpio_drive = gdrv_reg;
  assign lcd_drive = ldrv_reg;
  assign host_drive = hdrv_reg;
  assign int_push_pull = inttype_reg;
  assign host_bus_width = width_reg[1:0];
  assign read_dummy_byte = width_reg[mgcs_pkg::DUMMY_BIT];
  assign oscillator_trim = trim_reg;

endmodule

// ===== testbench/mgcs_regs_sva.sv
`timescale 1ns/100ps
// ============================================================
// Checker on the register bank ports.
module mgcs_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel, penable, pwrite, frame_done,
  input wire logic [31:0] paddr, pwdata,
  input wire logic [3:0] gpio_oe, gpio_out,
  input wire logic display_enable_pin, display_enable_oe,
  input wire logic [1:0] gpio_drive, host_drive, host_bus_width,
  input wire logic lcd_drive, int_push_pull, read_dummy_byte,
  input wire logic [4:0] oscillator_trim,
  input wire logic pready, pslverr
);
  logic [31:0] pwd_q;
  wire logic wr = psel && penable && pwrite;
  wire logic [21:0] a = paddr[21:0];
  always_ff @(posedge pclk) pwd_q <= pwdata;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dir_to_oe: assert property (wr && a == mgcs_pkg::OFS_DIR |=>
    gpio_oe == pwd_q[3:0]) else $error("direction bits not applied");
  a_display_enable_pin_dir: assert property (wr && a == mgcs_pkg::OFS_DIR |=>
    display_enable_oe == pwd_q[15]) else $error("display direction wrong");
  a_display_enable_pin_level: assert property (wr && a == mgcs_pkg::OFS_LEVEL |=>
    display_enable_pin == pwd_q[15]) else $error("display level wrong");
  a_level_out: assert property (wr && a == mgcs_pkg::OFS_LEVEL |=>
    gpio_out == pwd_q[3:0]) else $error("pin levels not applied");
  a_drive_fields: assert property (wr && a == mgcs_pkg::OFS_LEVEL |=>
    {gpio_drive, lcd_drive, host_drive, int_push_pull} == pwd_q[14:9])
    else $error("pad controls wrong");
  a_trim_field: assert property (wr && a == mgcs_pkg::OFS_TRIM |=>
    oscillator_trim == pwd_q[4:0]) else $error("trim not applied");
  a_width_set: assert property (wr && a == mgcs_pkg::OFS_WIDTH |=>
    read_dummy_byte == pwd_q[2]) else $error("dummy byte flag wrong");
  a_width_undef: assert property (wr && a == mgcs_pkg::OFS_WIDTH &&
    pwdata[1:0] == 2'h3 |=> $stable(host_bus_width))
    else $error("undefined width stored");
  a_idle_hold: assert property (!wr |=>
    $stable({gpio_oe, gpio_out, oscillator_trim})) else $error("idle change");
  a_bus_answer: assert property (pready && !pslverr)
    else $error("bus answer not ready");
  cover property (wr && a == mgcs_pkg::OFS_WIDTH && pwdata[1:0] == 2'h3);
  cover property (wr && a == mgcs_pkg::OFS_LEVEL && pwdata[3:0] != 4'h0);
  cover property ($rose(frame_done));
endmodule

bind mgcs_regs mgcs_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .frame_done, .paddr, .pwdata, .gpio_oe, .gpio_out,
  .display_enable_pin, .display_enable_oe, .gpio_drive, .host_drive,
  .host_bus_width, .lcd_drive, .int_push_pull, .read_dummy_byte,
  .oscillator_trim, .pready, .pslverr);

// ===== testbench/mgcs_pin_model.sv
`timescale 1ns/100ps
// ============================================================
// Pads: a pin set as output shows the bank's level, else the board's.
module mgcs_pin_model (
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] ext,
  output logic [3:0] gpio_in
);
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
// ============================================================
// Random and corner register traffic with read-back checks.
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, frame_done;
  logic [31:0] paddr, pwdata, prdata, q, d, dir, wx, t1, seed;
  logic [3:0] ext, gin, gout, goe;
  int n_fail = 0;
  int checks = 0;
  // The identity value is arbitrary.
  mgcs_regs #(.GPIO_LINES(4), .ID_VALUE(8'h3C)) u_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr(), .frame_done, .gpio_in(gin), .gpio_out(gout),
    .gpio_oe(goe), .display_enable_pin(), .display_enable_oe(),
    .gpio_drive(), .lcd_drive(), .host_drive(), .int_push_pull(),
    .host_bus_width(), .read_dummy_byte(), .oscillator_trim());
  mgcs_pin_model u_pins (.gpio_out(gout), .gpio_oe(goe), .ext, .gpio_in(gin));
  always #50 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0h got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Each transfer starts one edge after the previous one ends.
  task apb(input logic w, input logic [21:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'h1; pwrite <= w; paddr <= {10'h000, a}; pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rc(input logic [21:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h00000000);
    check_eq(q, exp);
  endtask
  initial begin
    #2000000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; frame_done = 0; ext = 0; seed = 32'h000013E1;
    wx = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rc(mgcs_pkg::OFS_ID, 32'h0000003C);
    rc(mgcs_pkg::OFS_FREQ, 32'h03938700);
    rc(mgcs_pkg::OFS_DIR, 32'h00008000);
    rc(mgcs_pkg::OFS_LEVEL, 32'h00008000);
    rc(mgcs_pkg::OFS_TRIM, 32'h00000000);
    rc(mgcs_pkg::OFS_WIDTH, 32'h00000000);
    rc(mgcs_pkg::OFS_FRAMES, 32'h00000000);
    apb(1'h0, mgcs_pkg::OFS_CYCLES, 32'h00000000);
    t1 = q;
    rc(mgcs_pkg::OFS_CYCLES, t1 + 32'h00000003);
    repeat (3) begin
      @(posedge pclk) frame_done <= 1'h1;
      repeat (2) @(posedge pclk);
      frame_done <= 1'h0;
      repeat (2) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
    rc(mgcs_pkg::OFS_FRAMES, 32'h00000003);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : seed;
      ext <= seed[7:4];
      apb(1'h1, mgcs_pkg::OFS_FREQ, d);
      rc(mgcs_pkg::OFS_FREQ, d);
      dir = d | 32'h00008000;
      apb(1'h1, mgcs_pkg::OFS_DIR, dir);
      rc(mgcs_pkg::OFS_DIR, dir & 32'h0000800F);
      apb(1'h1, mgcs_pkg::OFS_LEVEL, d);
      rc(mgcs_pkg::OFS_LEVEL, (d & 32'h0000FE00) | {28'h0000000,
        (dir[3:0] & d[3:0]) | (~dir[3:0] & ext)});
      apb(1'h1, mgcs_pkg::OFS_TRIM, d);
      rc(mgcs_pkg::OFS_TRIM, d & 32'h0000001F);
      apb(1'h1, mgcs_pkg::OFS_WIDTH, d);
      wx = {29'h00000000, d[2], (d[1:0] == 2'h3) ? wx[1:0] : d[1:0]};
      rc(mgcs_pkg::OFS_WIDTH, wx);
    end
    apb(1'h1, mgcs_pkg::OFS_ID, 32'hFFFFFFFF);
    rc(mgcs_pkg::OFS_ID, 32'h0000003C);
    apb(1'h1, 22'h000010, 32'hFFFFFFFF);
    rc(22'h000010, 32'h00000000);
    report_and_stop;
  end
endmodule
